//--- shared/rtc_cal_pkg.sv
// Constants for the time and calendar counter bank with minute and hour alarms.
// Assumes an 8-bit register port with a 4-bit address inside the clock device.
`default_nettype none
package rtc_cal_pkg;
  // ----------------------------------------------------------------
  // Register port geometry and addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_SECONDS = 4'h2;
  localparam logic [3:0] ADDR_MINUTE = 4'h3;
  localparam logic [3:0] ADDR_HOUR = 4'h4;
  localparam logic [3:0] ADDR_DAY = 4'h5;
  localparam logic [3:0] ADDR_WEEKDAY = 4'h6;
  localparam logic [3:0] ADDR_MONTH = 4'h7;
  localparam logic [3:0] ADDR_YEAR = 4'h8;
  localparam logic [3:0] ADDR_MINUTE_MATCH = 4'h9;
  localparam logic [3:0] ADDR_HOUR_MATCH = 4'hA;
  // ----------------------------------------------------------------
  // Implemented bits of each register and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_SECONDS = 8'h7F;
  localparam logic [7:0] MASK_MINUTE = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_DAY = 8'h3F;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_YEAR = 8'hFF;
  localparam logic [7:0] MASK_MINUTE_MATCH = 8'hFF;
  localparam logic [7:0] MASK_HOUR_MATCH = 8'hBF;
  localparam int OSC_STOPPED_BIT = 7;
  localparam int MATCH_DISABLE_BIT = 7;
  localparam int AFTERNOON_BIT = 5;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SECONDS = 8'h00;
  localparam logic RST_OSC_STOPPED = 1'b1;
  localparam logic [7:0] RST_MINUTE = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_WEEKDAY = 8'h00;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_MATCH = 8'h80;
  // ----------------------------------------------------------------
  // Counter limits in BCD
  // ----------------------------------------------------------------
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [4:0] HOUR12_LAST = 5'h11;
  localparam logic [4:0] HOUR12_TOP = 5'h12;
  localparam logic [4:0] HOUR12_FIRST = 5'h01;
  localparam logic [7:0] WEEKDAY_MAX = 8'h06;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
endpackage
`default_nettype wire

//--- hdl/bcd_step.sv
// One step of a two-digit BCD counter that wraps from a top value to a bottom value.
// Assumes the value holds legal BCD digits; the caller decides when the step is taken.
`default_nettype none
`timescale 1ns/100ps
module bcd_step (
  input wire logic [7:0] value,
  input wire logic [7:0] max_value,
  input wire logic [7:0] min_value,
  output logic [7:0] next_value,
  output logic at_max
);
  // ----------------------------------------------------------------
  // Increment with decimal carry between the digits
  // ----------------------------------------------------------------
  // The top value is compared whole, so a digit past nine never reaches a wrap.
  always_comb begin
    at_max = (value == max_value);
    if (at_max) begin
      next_value = min_value;
    end else if (value[3:0] == 4'h9) begin
      next_value = {value[7:4] + 4'h1, 4'h0};
    end else begin
      next_value = {value[7:4], value[3:0] + 4'h1};
    end
  end
endmodule // bcd_step
`default_nettype wire

//--- hdl/rtc_calendar_counters_alarm.sv
// Time and calendar counters, seconds to years, with minute and hour alarm compare.
// Assumes a serial front end that drives the register port and raises ACCESS_ACTIVE
// for the whole of each host access, and a 1 Hz one-cycle tick from the oscillator.
`default_nettype none
`timescale 1ns/100ps
module rtc_calendar_counters_alarm (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic TICK_1HZ,
  input wire logic OSC_STOPPED,
  input wire logic HOUR_FORMAT_12,
  input wire logic ACCESS_ACTIVE,
  input wire logic [rtc_cal_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [rtc_cal_pkg::DATA_W-1:0] REG_WDATA,
  output logic [rtc_cal_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic MATCH_FLAG_CLEAR,
  output logic MATCH_FLAG
);
  import rtc_cal_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] seconds_count, minute_count, hour_count, day_count;
  logic [7:0] weekday_count, month_count, year_count;
  logic [7:0] minute_match, hour_match;
  logic oscillator_stopped_flag, pending, match_flag, match_prev;
  logic [7:0] read_data;
  logic [7:0] next_seconds, next_minute, next_hour, next_day;
  logic [7:0] next_weekday, next_month, next_year;
  logic [7:0] next_minute_match, next_hour_match, next_read_data;
  logic next_oscillator_stopped_flag, next_pending, next_match_flag;
  logic step, hour_carry, match_now, minute_match_disable, hour_match_disable;
  logic [7:0] sec_inc, min_inc, day_inc, wd_inc, mon_inc, year_inc, hour_inc, day_max;
  logic sec_top, min_top, day_top, wd_top, mon_top, year_top;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Leap test on a BCD year: an even tens digit needs units 0, 4 or 8,
  // an odd tens digit needs units 2 or 6; year 00 counts as leap.
  function automatic logic is_leap(input logic [7:0] year);
    logic [3:0] u;
    u = year[3:0];
    if (year[4] == 1'b0) begin
      is_leap = (u == 4'h0) || (u == 4'h4) || (u == 4'h8);
    end else begin
      is_leap = (u == 4'h2) || (u == 4'h6);
    end
  endfunction

  // Length of the current month as a BCD day number.
  function automatic logic [7:0] month_length(input logic [7:0] month, input logic leap);
    if (month == MONTH_FEB) begin
      month_length = leap ? DAYS_29 : DAYS_28;
    end else if ((month == MONTH_APR) || (month == MONTH_JUN) ||
                 (month == MONTH_SEP) || (month == MONTH_NOV)) begin
      month_length = DAYS_30;
    end else begin
      month_length = DAYS_31;
    end
  endfunction

  // Register file read mux; unmapped addresses read as zero.
  function automatic logic [7:0] read_mux(input logic [3:0] addr);
    unique case (addr)
      ADDR_SECONDS: read_mux = {oscillator_stopped_flag, seconds_count[6:0]};
      ADDR_MINUTE: read_mux = minute_count;
      ADDR_HOUR: read_mux = hour_count;
      ADDR_DAY: read_mux = day_count;
      ADDR_WEEKDAY: read_mux = weekday_count;
      ADDR_MONTH: read_mux = month_count;
      ADDR_YEAR: read_mux = year_count;
      ADDR_MINUTE_MATCH: read_mux = minute_match;
      ADDR_HOUR_MATCH: read_mux = hour_match;
      default: read_mux = BCD_ZERO;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Digit counters
  // ----------------------------------------------------------------
  bcd_step u_sec (.value(seconds_count), .max_value(SEC_MAX), .min_value(BCD_ZERO),
    .next_value(sec_inc), .at_max(sec_top));
  bcd_step u_min (.value(minute_count), .max_value(MIN_MAX), .min_value(BCD_ZERO),
    .next_value(min_inc), .at_max(min_top));
  bcd_step u_day (.value(day_count), .max_value(day_max), .min_value(BCD_ONE),
    .next_value(day_inc), .at_max(day_top));
  bcd_step u_wd (.value(weekday_count), .max_value(WEEKDAY_MAX), .min_value(BCD_ZERO),
    .next_value(wd_inc), .at_max(wd_top));
  bcd_step u_mon (.value(month_count), .max_value(MONTH_MAX), .min_value(BCD_ONE),
    .next_value(mon_inc), .at_max(mon_top));
  bcd_step u_year (.value(year_count), .max_value(YEAR_MAX), .min_value(BCD_ZERO),
    .next_value(year_inc), .at_max(year_top));

  // ----------------------------------------------------------------
  // Hour advance in either format
  // ----------------------------------------------------------------
  // In 12 hour mode 11 goes to 12 with the afternoon bit toggled, and 12 goes
  // to 01; the day only turns over at 11 PM to 12 AM.
  always_comb begin
    hour_inc = hour_count;
    hour_carry = 1'b0;
    if (HOUR_FORMAT_12) begin
      if (hour_count[4:0] == HOUR12_LAST) begin
        hour_inc = {2'b00, ~hour_count[AFTERNOON_BIT], HOUR12_TOP};
        hour_carry = hour_count[AFTERNOON_BIT];
      end else if (hour_count[4:0] == HOUR12_TOP) begin
        hour_inc = {2'b00, hour_count[AFTERNOON_BIT], HOUR12_FIRST};
      end else if (hour_count[3:0] == 4'h9) begin
        hour_inc = {2'b00, hour_count[AFTERNOON_BIT], 5'h10};
      end else begin
        hour_inc = {hour_count[7:4], hour_count[3:0] + 4'h1};
      end
    end else begin
      if (hour_count == HOUR24_MAX) begin
        hour_inc = BCD_ZERO;
        hour_carry = 1'b1;
      end else if (hour_count[3:0] == 4'h9) begin
        hour_inc = {hour_count[7:4] + 4'h1, 4'h0};
      end else begin
        hour_inc = {hour_count[7:4], hour_count[3:0] + 4'h1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic for counters, alarms and flags
  // ----------------------------------------------------------------
  // A host write also holds off the step, so a written value is never mixed
  // with a carry in the same cycle; the tick is then kept pending instead.
  always_comb begin
    day_max = month_length(month_count, is_leap(year_count));
    step = !ACCESS_ACTIVE && !REG_WR && (TICK_1HZ || pending);
    next_pending = (TICK_1HZ && (ACCESS_ACTIVE || REG_WR)) || (pending && !step);
    next_seconds = seconds_count;
    next_minute = minute_count;
    next_hour = hour_count;
    next_day = day_count;
    next_weekday = weekday_count;
    next_month = month_count;
    next_year = year_count;
    next_minute_match = minute_match;
    next_hour_match = hour_match;
    next_oscillator_stopped_flag = oscillator_stopped_flag;
    if (step) begin
      next_seconds = sec_inc;
      if (sec_top) begin
        next_minute = min_inc;
        if (min_top) begin
          next_hour = hour_inc;
          if (hour_carry) begin
            next_day = day_inc;
            next_weekday = wd_inc;
            if (day_top) begin
              next_month = mon_inc;
              if (mon_top) begin
                next_year = year_inc;
              end
            end
          end
        end
      end
    end
    if (REG_WR) begin
      // Unimplemented bits are dropped on the way in.
      unique case (REG_ADDR)
        ADDR_SECONDS: begin
          next_seconds = REG_WDATA & MASK_SECONDS;
          next_oscillator_stopped_flag = REG_WDATA[OSC_STOPPED_BIT];
        end
        ADDR_MINUTE: next_minute = REG_WDATA & MASK_MINUTE;
        ADDR_HOUR: next_hour = REG_WDATA & MASK_HOUR;
        ADDR_DAY: next_day = REG_WDATA & MASK_DAY;
        ADDR_WEEKDAY: next_weekday = REG_WDATA & MASK_WEEKDAY;
        ADDR_MONTH: next_month = REG_WDATA & MASK_MONTH;
        ADDR_YEAR: next_year = REG_WDATA & MASK_YEAR;
        ADDR_MINUTE_MATCH: next_minute_match = REG_WDATA & MASK_MINUTE_MATCH;
        ADDR_HOUR_MATCH: next_hour_match = REG_WDATA & MASK_HOUR_MATCH;
        default: ;
      endcase
    end
    // The stopped oscillator wins over a software clear in the same cycle.
    if (OSC_STOPPED) begin
      next_oscillator_stopped_flag = 1'b1;
    end
    next_read_data = REG_RD ? read_mux(REG_ADDR) : read_data;
  end

  // ----------------------------------------------------------------
  // Alarm compare and flag
  // ----------------------------------------------------------------
  // With no alarm enabled nothing matches. The flag fires on the edge into a
  // match, so a clear during a lasting match does not fire it again.
  always_comb begin
    minute_match_disable = minute_match[MATCH_DISABLE_BIT];
    hour_match_disable = hour_match[MATCH_DISABLE_BIT];
    match_now = (!minute_match_disable || !hour_match_disable) &&
                (minute_match_disable || (minute_match[6:0] == minute_count[6:0])) &&
                (hour_match_disable || (hour_match[5:0] == hour_count[5:0]));
    next_match_flag = match_flag && !MATCH_FLAG_CLEAR;
    if (match_now && !match_prev) begin
      next_match_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      seconds_count <= RST_SECONDS;
      minute_count <= RST_MINUTE;
      hour_count <= RST_HOUR;
      day_count <= RST_DAY;
      weekday_count <= RST_WEEKDAY;
      month_count <= RST_MONTH;
      year_count <= RST_YEAR;
      minute_match <= RST_MATCH;
      hour_match <= RST_MATCH;
      oscillator_stopped_flag <= RST_OSC_STOPPED;
      pending <= 1'b0;
      match_flag <= 1'b0;
      match_prev <= 1'b0;
      read_data <= BCD_ZERO;
    end else begin
      seconds_count <= next_seconds;
      minute_count <= next_minute;
      hour_count <= next_hour;
      day_count <= next_day;
      weekday_count <= next_weekday;
      month_count <= next_month;
      year_count <= next_year;
      minute_match <= next_minute_match;
      hour_match <= next_hour_match;
      oscillator_stopped_flag <= next_oscillator_stopped_flag;
      pending <= next_pending;
      match_flag <= next_match_flag;
      match_prev <= match_now;
      read_data <= next_read_data;
    end
  end

  assign REG_RDATA = read_data;
  assign MATCH_FLAG = match_flag;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence sec_carry_s;
    step && (seconds_count == SEC_MAX);
  endsequence
  sequence hour_carry_s;
    sec_carry_s and (minute_count == MIN_MAX);
  endsequence

  // A tick taken during the access must be left pending; an idle access keeps pending as is.
  frozen_counters_a: assert property ((ACCESS_ACTIVE && !REG_WR) |=>
    $stable(seconds_count) && $stable(minute_count) && $stable(day_count) &&
    (pending || !$past(TICK_1HZ)))
    else $error("Counters moved or tick lost during an access.");
  pending_served_a: assert property ((pending && !ACCESS_ACTIVE && !REG_WR) |=>
    !pending && (seconds_count != $past(seconds_count)))
    else $error("Pending tick was not served after the access.");
  minute_roll_a: assert property (sec_carry_s ##0 (minute_count == MIN_MAX) |=>
    (minute_count == BCD_ZERO) && (seconds_count == BCD_ZERO))
    else $error("Minute did not wrap to zero.");
  hour24_roll_a: assert property (hour_carry_s ##0
    (!HOUR_FORMAT_12 && hour_count == HOUR24_MAX) |=>
    (hour_count == BCD_ZERO) && (weekday_count != $past(weekday_count)))
    else $error("24 hour wrap did not advance the day.");
  noon_turn_a: assert property (hour_carry_s ##0
    (HOUR_FORMAT_12 && hour_count == 8'h11) |=>
    (hour_count == 8'h32) && $stable(day_count))
    else $error("12 hour clock did not turn to 12 PM.");
  leap_feb_a: assert property ((month_count == MONTH_FEB && year_count == BCD_ZERO) |->
    day_max == DAYS_29)
    else $error("Year 00 February is not 29 days.");
  weekday_wrap_a: assert property (
    (hour_carry_s ##0 hour_carry && weekday_count == WEEKDAY_MAX) |=> weekday_count == BCD_ZERO)
    else $error("Weekday did not wrap from 6 to 0.");
  unused_zero_a: assert property (
    (minute_count[7] == 1'b0) && (hour_count[7:6] == 2'b00) &&
    (day_count[7:6] == 2'b00) && (weekday_count[7:3] == 5'h00) && (month_count[7:5] == 3'h0))
    else $error("Unused register bit is set.");
  alarm_off_a: assert property (
    (minute_match_disable && hour_match_disable) |-> !match_now)
    else $error("Disabled alarms produced a match.");
  match_set_a: assert property ((match_now && !match_prev) |=> MATCH_FLAG ##1
    (MATCH_FLAG || $past(MATCH_FLAG_CLEAR)))
    else $error("Alarm flag not set on a new match.");
  osc_flag_a: assert property (OSC_STOPPED |=> REG_RDATA == $past(REG_RDATA) ||
    oscillator_stopped_flag)
    else $error("Oscillator stopped flag lost.");
endmodule // rtc_calendar_counters_alarm
`default_nettype wire

//--- sim/rtc_host_model.sv
// Model of the host that reaches the time and alarm registers through the register port.
// Assumes one calling process; every drive after time zero is a non-blocking change at a CLK_SYS edge.
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
  input wire logic CLK_SYS,
  output var logic ACCESS_ACTIVE,
  output var logic [rtc_cal_pkg::ADDR_W-1:0] REG_ADDR,
  output var logic REG_WR,
  output var logic REG_RD,
  output var logic [rtc_cal_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic [rtc_cal_pkg::DATA_W-1:0] REG_RDATA
);
  import rtc_cal_pkg::*;
  // ----------------------------------------------------------------
  // Access framing and byte transfers
  // ----------------------------------------------------------------
  // Strobes idle from time zero, so nothing is taken before the first call.
  initial begin
    ACCESS_ACTIVE = 1'b0;
    REG_ADDR = 4'hF;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 8'h00;
  end
  // All bytes of a time setting or reading go inside one access.
  task automatic open_access();
    @(posedge CLK_SYS);
    ACCESS_ACTIVE <= 1'b1;
  endtask
  // Accesses last under a hundred cycles, far inside one second of ticks.
  task automatic close_access();
    @(posedge CLK_SYS);
    ACCESS_ACTIVE <= 1'b0;
  endtask
  // The released data lines show the inverse, so a stale byte cannot pass for a fresh one.
  task automatic write_byte(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(posedge CLK_SYS);
    REG_ADDR <= addr;
    REG_WDATA <= data;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
    REG_WDATA <= ~data;
  endtask
  // Read data is taken one cycle after the strobe edge and then stands.
  task automatic read_byte(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
    @(posedge CLK_SYS);
    REG_ADDR <= addr;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    @(posedge CLK_SYS);
    data = REG_RDATA;
  endtask
endmodule // rtc_host_model
`default_nettype wire

//--- sim/rtc_calendar_counters_alarm_tb.sv
// Self-checking bench for the time and calendar counters with minute and hour alarms.
// Assumes the host model drives the register port; the bench drives ticks and flags.
`timescale 1ns/100ps
`default_nettype none
module rtc_calendar_counters_alarm_tb;
  import rtc_cal_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic tick_1hz = 1'b0;
  logic osc_stopped = 1'b0;
  logic hour_format_12 = 1'b0;
  logic match_flag_clear = 1'b0;
  logic access_active;
  logic reg_wr;
  logic reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic match_flag;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] rst_tab [10] = '{8'h80, RST_MINUTE, RST_HOUR, RST_DAY, RST_WEEKDAY, RST_MONTH,
    RST_YEAR, RST_MATCH, RST_MATCH, 8'h00};
  logic [7:0] mask_tab [9] = '{MASK_MINUTE, MASK_HOUR, MASK_DAY, MASK_WEEKDAY, MASK_MONTH,
    MASK_YEAR, MASK_MINUTE_MATCH, MASK_HOUR_MATCH, 8'h00};

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  // Free-running 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  rtc_calendar_counters_alarm rtc_calendar_counters_alarm_i (.CLK_SYS(clk_sys), .RST(rst),
    .TICK_1HZ(tick_1hz), .OSC_STOPPED(osc_stopped), .HOUR_FORMAT_12(hour_format_12),
    .ACCESS_ACTIVE(access_active), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .MATCH_FLAG_CLEAR(match_flag_clear),
    .MATCH_FLAG(match_flag));

  rtc_host_model rtc_host_model_i (.CLK_SYS(clk_sys), .ACCESS_ACTIVE(access_active),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s gave %h, expected %h", $time, what, got, exp);
    end
  endtask
  task automatic one_tick();
    @(posedge clk_sys);
    tick_1hz <= 1'b1;
    @(posedge clk_sys);
    tick_1hz <= 1'b0;
  endtask
  task automatic pulse_clear();
    @(posedge clk_sys);
    match_flag_clear <= 1'b1;
    @(posedge clk_sys);
    match_flag_clear <= 1'b0;
  endtask
  // Time vectors are written year first, so element 0 is seconds at the lowest address.
  task automatic set_time(input logic [6:0][7:0] t);
    rtc_host_model_i.open_access();
    for (int i = 0; i < 7; i++) rtc_host_model_i.write_byte(ADDR_SECONDS + 4'(i), t[i]);
    rtc_host_model_i.close_access();
  endtask
  task automatic check_time(input logic [6:0][7:0] t, input string what);
    logic [7:0] d;
    rtc_host_model_i.open_access();
    for (int i = 0; i < 7; i++) begin
      rtc_host_model_i.read_byte(ADDR_SECONDS + 4'(i), d);
      chk(d, t[i], what);
    end
    rtc_host_model_i.close_access();
  endtask
  task automatic roll(input logic [6:0][7:0] from, input logic [6:0][7:0] to, input string what);
    set_time(from);
    one_tick();
    repeat (2) @(posedge clk_sys);
    check_time(to, what);
  endtask
  task automatic flag_is(input logic exp, input string what);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, match_flag}, {7'h00, exp}, what);
  endtask

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  // A hang is cut short well inside the cycle budget.
  initial begin
    #500000;
    n_errors++;
    $display("ERROR at %0t: run did not finish", $time);
    finish_test();
  end

  // Scenarios run in order; each leaves the time in a known state for the next.
  initial begin
    logic [7:0] d;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rtc_host_model_i.open_access();
    for (int a = 2; a <= 11; a++) begin
      rtc_host_model_i.read_byte(4'(a), d);
      chk(d, rst_tab[a-2], "reset value");
    end
    for (int a = 3; a <= 11; a++) begin
      rtc_host_model_i.write_byte(4'(a), 8'hFF);
      rtc_host_model_i.read_byte(4'(a), d);
      chk(d, mask_tab[a-3], "unused bits");
    end
    rtc_host_model_i.close_access();
    $display("Test reset values and masks done");
    roll({8'h99, 8'h12, 8'h06, 8'h31, 8'h23, 8'h59, 8'h59},
      {8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, "full rollover");
    roll({8'h04, 8'h02, 8'h03, 8'h28, 8'h23, 8'h59, 8'h59},
      {8'h04, 8'h02, 8'h04, 8'h29, 8'h00, 8'h00, 8'h00}, "leap 04");
    roll({8'h00, 8'h02, 8'h03, 8'h28, 8'h23, 8'h59, 8'h59},
      {8'h00, 8'h02, 8'h04, 8'h29, 8'h00, 8'h00, 8'h00}, "leap 00");
    roll({8'h12, 8'h02, 8'h03, 8'h28, 8'h23, 8'h59, 8'h59},
      {8'h12, 8'h02, 8'h04, 8'h29, 8'h00, 8'h00, 8'h00}, "leap 12");
    roll({8'h10, 8'h02, 8'h03, 8'h28, 8'h23, 8'h59, 8'h59},
      {8'h10, 8'h03, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00}, "common 10");
    roll({8'h04, 8'h02, 8'h03, 8'h29, 8'h23, 8'h59, 8'h59},
      {8'h04, 8'h03, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00}, "leap end");
    roll({8'h21, 8'h09, 8'h01, 8'h30, 8'h23, 8'h59, 8'h59},
      {8'h21, 8'h10, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00}, "thirty days");
    roll({8'h21, 8'h05, 8'h01, 8'h09, 8'h09, 8'h59, 8'h59},
      {8'h21, 8'h05, 8'h01, 8'h09, 8'h10, 8'h00, 8'h00}, "hour digit");
    hour_format_12 <= 1'b1;
    roll({8'h21, 8'h05, 8'h01, 8'h09, 8'h11, 8'h59, 8'h59},
      {8'h21, 8'h05, 8'h01, 8'h09, 8'h32, 8'h00, 8'h00}, "noon");
    roll({8'h21, 8'h05, 8'h01, 8'h09, 8'h32, 8'h59, 8'h59},
      {8'h21, 8'h05, 8'h01, 8'h09, 8'h21, 8'h00, 8'h00}, "one pm");
    roll({8'h21, 8'h05, 8'h01, 8'h09, 8'h31, 8'h59, 8'h59},
      {8'h21, 8'h05, 8'h02, 8'h10, 8'h12, 8'h00, 8'h00}, "midnight");
    hour_format_12 <= 1'b0;
    $display("Test rollovers done");
    set_time({8'h24, 8'h06, 8'h02, 8'h15, 8'h10, 8'h30, 8'h10});
    rtc_host_model_i.open_access();
    repeat (2) one_tick();
    rtc_host_model_i.read_byte(ADDR_SECONDS, d);
    chk(d, 8'h10, "frozen seconds");
    rtc_host_model_i.close_access();
    repeat (3) @(posedge clk_sys);
    check_time({8'h24, 8'h06, 8'h02, 8'h15, 8'h10, 8'h30, 8'h11}, "one pending");
    @(posedge clk_sys);
    osc_stopped <= 1'b1;
    @(posedge clk_sys);
    osc_stopped <= 1'b0;
    rtc_host_model_i.open_access();
    rtc_host_model_i.read_byte(ADDR_SECONDS, d);
    chk(d, 8'h91, "stopped flag set");
    rtc_host_model_i.write_byte(ADDR_SECONDS, 8'h59);
    rtc_host_model_i.read_byte(ADDR_SECONDS, d);
    chk(d, 8'h59, "stopped flag cleared");
    // Any new match sets the flag, so no half-written alarm may match the time.
    rtc_host_model_i.write_byte(ADDR_MINUTE_MATCH, 8'h31);
    rtc_host_model_i.write_byte(ADDR_HOUR_MATCH, 8'h10);
    rtc_host_model_i.close_access();
    $display("Test freeze and stopped flag done");
    flag_is(1'b0, "flag before match");
    one_tick();
    flag_is(1'b1, "flag on minute match");
    pulse_clear();
    flag_is(1'b0, "flag after clear");
    rtc_host_model_i.open_access();
    rtc_host_model_i.write_byte(ADDR_HOUR_MATCH, 8'h11);
    rtc_host_model_i.write_byte(ADDR_MINUTE_MATCH, 8'hB1);
    rtc_host_model_i.write_byte(ADDR_MINUTE, 8'h59);
    rtc_host_model_i.write_byte(ADDR_SECONDS, 8'h59);
    rtc_host_model_i.close_access();
    flag_is(1'b0, "flag hour mismatch");
    one_tick();
    flag_is(1'b1, "flag on hour match");
    $display("Test alarm done");
    finish_test();
  end
endmodule // rtc_calendar_counters_alarm_tb
`default_nettype wire
